// File: rtl/bridge_prot_pkg.sv
// package: register map, field layout, reset values and timing for bridge fault protection
package bridge_prot_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] short_detect_config_off = 8'h00;
	localparam logic [7:0] temp_config_off = 8'h04;
	localparam logic [7:0] driver_control_off = 8'h08;
	localparam logic [7:0] driver_status_word_off = 8'h0c;
	localparam logic [7:0] irq_status_off = 8'h10;
	localparam logic [7:0] irq_mask_off = 8'h14;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [3:0] lowside_thr_rst = 4'hc;
	localparam logic [3:0] highside_thr_rst = 4'hc;
	localparam logic [1:0] spike_filter_rst = 2'h1;
	localparam logic [1:0] retry_rst = 2'h3;
	localparam logic [1:0] temp_level_rst = 2'h0;
	localparam logic [7:0] irq_mask_rst = 8'h00;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int clk_mhz = 100;
	localparam int filt0_ns = 100;
	localparam int filt_step_ns = 1000;
	localparam int delay_short_ns = 750;
	localparam int delay_long_ns = 1500;
	localparam int filt0_cyc = (filt0_ns * clk_mhz + 999) / 1000;
	localparam int filt_step_cyc = (filt_step_ns * clk_mhz + 999) / 1000;
	localparam int delay_short_cyc = (delay_short_ns * clk_mhz + 999) / 1000;
	localparam int delay_long_cyc = (delay_long_ns * clk_mhz + 999) / 1000;
	localparam int cnt_w = 10;

	// ----------------------------------------
	// interrupt status bit positions
	// ----------------------------------------
	localparam int irq_prewarn = 0;
	localparam int irq_shutdown = 1;
	localparam int irq_short = 2;
	localparam int irq_perm = 3;

	// short detector configuration
	typedef struct packed {
		logic whole_bridge_trip;
		logic highside_fault_detect_off;
		logic lowside_fault_detect_off;
		logic long_delay;
		logic [1:0] retry;
		logic [1:0] spike_filter_setting;
		logic [3:0] highside_ground_fault_threshold;
		logic [3:0] lowside_overcurrent_threshold;
	} short_cfg_s;

	// per-phase latched fault flags
	typedef struct packed {
		logic [2:0] ground_fault;
		logic [2:0] supply_fault;
	} fault_flags_s;

	typedef enum logic [1:0] {trans_idle = 2'h0, trans_busy = 2'h1, trans_nonseq = 2'h2, trans_seq = 2'h3} htrans_e;

endpackage

// File: rtl/bridge_fault_protection.sv
// bridge fault protection: overtemperature, per-phase short detection and ahb-lite registers
`timescale 1ns/1ps
module bridge_fault_protection #(
	parameter int phases = 3
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [3:0] otp_lowside_thr,
	input wire logic [3:0] otp_highside_thr,
	input wire logic [3:0] temp_cmp,
	input wire logic [phases-1:0] gate_hs,
	input wire logic [phases-1:0] gate_ls,
	input wire logic [phases-1:0] hs_drop_cmp,
	input wire logic [phases-1:0] ls_drop_cmp,
	output logic [phases-1:0] bridge_enable,
	output logic [3:0] lowside_overcurrent_threshold,
	output logic [3:0] highside_ground_fault_threshold,
	output logic fault_n,
	output logic irq
);

	// ----------------------------------------
	// pin synchronisers (three stages, change counts when last two agree)
	// ----------------------------------------
	localparam int sync_w = 4 + 4 * phases;
	logic [sync_w-1:0] pin_raw;
	logic [sync_w-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
	assign pin_raw = {temp_cmp, gate_hs, gate_ls, hs_drop_cmp, ls_drop_cmp};

	// accept a new pin level only when the second and third stages agree
	always_comb begin
		for (int i = 0; i < sync_w; i++) begin
			pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
		end
	end

	logic [3:0] temp_s;
	logic [phases-1:0] hs_on, ls_on, hs_drop, ls_drop;
	assign {temp_s, hs_on, ls_on, hs_drop, ls_drop} = pin_q;

	// ----------------------------------------
	// register state
	// ----------------------------------------
	bridge_prot_pkg::short_cfg_s cfg_q, cfg_d;
	logic [1:0] temp_level_q, temp_level_d;
	logic drv_en_q, drv_en_d;
	logic short_direct_q, short_direct_d;
	logic [7:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
	logic otp_load_q;
	logic wr_pend_q, wr_pend_d;
	logic [7:0] wr_addr_q, wr_addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic [7:0] irq_ev;
	logic [31:0] status_word;

	// ----------------------------------------
	// overtemperature
	// ----------------------------------------
	// temp_s[0] prewarn comparator, temp_s[3:1] the three shutdown levels
	logic prewarn, shut_hit, overtemp_shutdown_flag_q, overtemp_shutdown_flag_d;
	assign prewarn = temp_s[0];
	always_comb begin
		case (temp_level_q)
			2'h0: shut_hit = temp_s[1];
			2'h1: shut_hit = temp_s[2];
			default: shut_hit = temp_s[3];
		endcase
		overtemp_shutdown_flag_d = overtemp_shutdown_flag_q;
		if (shut_hit) begin
			overtemp_shutdown_flag_d = 1'b1;
		end else if (!prewarn) begin
			overtemp_shutdown_flag_d = 1'b0;
		end
	end

	// ----------------------------------------
	// short detection per phase
	// ----------------------------------------
	logic [bridge_prot_pkg::cnt_w-1:0] blank_lim, filt_lim;
	always_comb begin
		blank_lim = cfg_q.long_delay ? bridge_prot_pkg::cnt_w'(bridge_prot_pkg::delay_long_cyc)
			: bridge_prot_pkg::cnt_w'(bridge_prot_pkg::delay_short_cyc);
		if (cfg_q.spike_filter_setting == 2'h0) begin
			filt_lim = bridge_prot_pkg::cnt_w'(bridge_prot_pkg::filt0_cyc);
		end else begin
			filt_lim = bridge_prot_pkg::cnt_w'(bridge_prot_pkg::filt_step_cyc) *
				bridge_prot_pkg::cnt_w'(cfg_q.spike_filter_setting);
		end
	end

	logic [phases-1:0] hs_cand, ls_cand, hs_conf, ls_conf, pulse;
	logic [phases-1:0] off_q, off_d;
	logic [bridge_prot_pkg::cnt_w-1:0] hs_blank_q [phases], hs_blank_d [phases];
	logic [bridge_prot_pkg::cnt_w-1:0] ls_blank_q [phases], ls_blank_d [phases];
	logic [bridge_prot_pkg::cnt_w-1:0] hs_filt_q [phases], hs_filt_d [phases];
	logic [bridge_prot_pkg::cnt_w-1:0] ls_filt_q [phases], ls_filt_d [phases];

	// blanking counts from each switch-on edge, the filter a steady drop; a phase already being
	// switched off is masked so one short never eats two retries while the enable output lags
	for (genvar p = 0; p < phases; p++) begin : g_det
		assign hs_cand[p] = hs_on[p] && bridge_enable[p] && !off_q[p] && !cfg_q.highside_fault_detect_off &&
			hs_blank_q[p] >= blank_lim && hs_drop[p];
		assign ls_cand[p] = ls_on[p] && bridge_enable[p] && !off_q[p] && !cfg_q.lowside_fault_detect_off &&
			ls_blank_q[p] >= blank_lim && ls_drop[p];
		assign hs_conf[p] = hs_cand[p] && hs_filt_q[p] >= filt_lim;
		assign ls_conf[p] = ls_cand[p] && ls_filt_q[p] >= filt_lim;
		assign pulse[p] = hs_cand[p] || ls_cand[p];
		always_comb begin
			hs_blank_d[p] = !hs_on[p] ? '0 : (hs_blank_q[p] < blank_lim ? hs_blank_q[p] + 1'b1 : hs_blank_q[p]);
			ls_blank_d[p] = !ls_on[p] ? '0 : (ls_blank_q[p] < blank_lim ? ls_blank_q[p] + 1'b1 : ls_blank_q[p]);
			hs_filt_d[p] = !hs_cand[p] ? '0 : (hs_filt_q[p] < filt_lim ? hs_filt_q[p] + 1'b1 : hs_filt_q[p]);
			ls_filt_d[p] = !ls_cand[p] ? '0 : (ls_filt_q[p] < filt_lim ? ls_filt_q[p] + 1'b1 : ls_filt_q[p]);
		end
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				hs_blank_q[p] <= '0;
				ls_blank_q[p] <= '0;
				hs_filt_q[p] <= '0;
				ls_filt_q[p] <= '0;
			end else begin
				hs_blank_q[p] <= hs_blank_d[p];
				ls_blank_q[p] <= ls_blank_d[p];
				hs_filt_q[p] <= hs_filt_d[p];
				ls_filt_q[p] <= ls_filt_d[p];
			end
		end
	end

	// ----------------------------------------
	// retry and shutdown latching
	// ----------------------------------------
	// a retry switches the phase off for one cycle; once the budget
	// is used up the next short is permanent
	bridge_prot_pkg::fault_flags_s flags_q, flags_d;
	logic [1:0] retry_cnt_q, retry_cnt_d;
	logic perm_q, perm_d;
	logic any_conf;
	assign any_conf = |(hs_conf | ls_conf);

	always_comb begin
		flags_d = flags_q;
		retry_cnt_d = retry_cnt_q;
		perm_d = perm_q;
		off_d = off_q;
		if (!drv_en_q) begin
			flags_d = '0;
			retry_cnt_d = '0;
			perm_d = 1'b0;
			off_d = '0;
		end else if (any_conf) begin
			flags_d.ground_fault = flags_q.ground_fault | hs_conf;
			flags_d.supply_fault = flags_q.supply_fault | ls_conf;
			off_d = cfg_q.whole_bridge_trip ? '1 : (off_q | hs_conf | ls_conf);
			if (retry_cnt_q >= cfg_q.retry) begin
				perm_d = 1'b1;
			end else begin
				retry_cnt_d = retry_cnt_q + 2'h1;
			end
		end else if (!perm_q) begin
			off_d = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flags_q <= '0;
			retry_cnt_q <= '0;
			perm_q <= 1'b0;
			off_q <= '0;
			overtemp_shutdown_flag_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			retry_cnt_q <= retry_cnt_d;
			perm_q <= perm_d;
			off_q <= off_d;
			overtemp_shutdown_flag_q <= overtemp_shutdown_flag_d;
		end
	end

	// ----------------------------------------
	// ahb-lite slave, zero wait states
	// ----------------------------------------
	logic take;
	assign take = hsel && hready && htrans[1];
	assign irq_ev = {4'h0, perm_d && !perm_q, any_conf && drv_en_q, overtemp_shutdown_flag_d && !overtemp_shutdown_flag_q,
		prewarn};
	assign status_word = {20'h0, perm_q, overtemp_shutdown_flag_q, prewarn, retry_cnt_q,
		flags_q.supply_fault, flags_q.ground_fault, 1'b0};

	function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] st);
		case (a)
			bridge_prot_pkg::short_detect_config_off: rd_mux = {16'h0, cfg_q};
			bridge_prot_pkg::temp_config_off: rd_mux = {30'h0, temp_level_q};
			bridge_prot_pkg::driver_control_off: rd_mux = {30'h0, short_direct_q, drv_en_q};
			bridge_prot_pkg::driver_status_word_off: rd_mux = st;
			bridge_prot_pkg::irq_status_off: rd_mux = {24'h0, irq_st_q};
			bridge_prot_pkg::irq_mask_off: rd_mux = {24'h0, irq_mask_q};
			default: rd_mux = 32'h0;
		endcase
	endfunction

	// register writes land in the data phase; set wins over write-one-to-clear
	always_comb begin
		cfg_d = cfg_q;
		temp_level_d = temp_level_q;
		drv_en_d = drv_en_q;
		short_direct_d = short_direct_q;
		irq_mask_d = irq_mask_q;
		irq_st_d = irq_st_q;
		wr_pend_d = take && hwrite;
		wr_addr_d = haddr;
		hrdata_d = (take && !hwrite) ? rd_mux(haddr, status_word) : 32'h0;
		if (otp_load_q) begin
			cfg_d.lowside_overcurrent_threshold = otp_lowside_thr;
			cfg_d.highside_ground_fault_threshold = otp_highside_thr;
		end
		if (wr_pend_q) begin
			case (wr_addr_q)
				bridge_prot_pkg::short_detect_config_off: cfg_d = hwdata[15:0];
				bridge_prot_pkg::temp_config_off: temp_level_d = hwdata[1:0];
				bridge_prot_pkg::driver_control_off: begin
					drv_en_d = hwdata[0];
					short_direct_d = hwdata[1];
				end
				bridge_prot_pkg::irq_status_off: irq_st_d = irq_st_q & ~hwdata[7:0];
				bridge_prot_pkg::irq_mask_off: irq_mask_d = hwdata[7:0];
				default: ;
			endcase
		end
		if (cfg_d.highside_ground_fault_threshold < 4'h2) begin
			cfg_d.highside_ground_fault_threshold = 4'h2;
		end
		irq_st_d = irq_st_d | irq_ev;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_q <= '{whole_bridge_trip: 1'b1, highside_fault_detect_off: 1'b0, lowside_fault_detect_off: 1'b0,
				long_delay: 1'b0, retry: bridge_prot_pkg::retry_rst,
				spike_filter_setting: bridge_prot_pkg::spike_filter_rst,
				highside_ground_fault_threshold: bridge_prot_pkg::highside_thr_rst,
				lowside_overcurrent_threshold: bridge_prot_pkg::lowside_thr_rst};
			temp_level_q <= bridge_prot_pkg::temp_level_rst;
			drv_en_q <= 1'b0;
			short_direct_q <= 1'b0;
			irq_st_q <= '0;
			irq_mask_q <= bridge_prot_pkg::irq_mask_rst;
			otp_load_q <= 1'b1;
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q <= '0;
		end else begin
			cfg_q <= cfg_d;
			temp_level_q <= temp_level_d;
			drv_en_q <= drv_en_d;
			short_direct_q <= short_direct_d;
			irq_st_q <= irq_st_d;
			irq_mask_q <= irq_mask_d;
			otp_load_q <= 1'b0; // otp straps are caught on the first edge after release
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q <= hrdata_d;
		end
	end

	// ----------------------------------------
	// outputs, all registered
	// ----------------------------------------
	logic [phases-1:0] bridge_enable_d;
	logic fault_n_d;
	always_comb begin
		bridge_enable_d = {phases{drv_en_q && !overtemp_shutdown_flag_q}} & ~off_q;
		fault_n_d = !(perm_q || overtemp_shutdown_flag_q || (short_direct_q && |pulse));
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bridge_enable <= '0;
			fault_n <= 1'b1;
			irq <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			lowside_overcurrent_threshold <= bridge_prot_pkg::lowside_thr_rst;
			highside_ground_fault_threshold <= bridge_prot_pkg::highside_thr_rst;
		end else begin
			bridge_enable <= bridge_enable_d;
			fault_n <= fault_n_d;
			irq <= |(irq_st_d & irq_mask_d);
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			lowside_overcurrent_threshold <= cfg_q.lowside_overcurrent_threshold;
			highside_ground_fault_threshold <= cfg_q.highside_ground_fault_threshold;
		end
	end

	assign hrdata = hrdata_q;

endmodule

// File: sim/bridge_fault_protection_chk.sv
// checker: port-level assertions for the bridge fault protection block
`timescale 1ns/1ps
module bridge_prot_chk #(
	parameter int phases = 3
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [3:0] temp_cmp,
	input wire logic [phases-1:0] bridge_enable,
	input wire logic fault_n,
	input wire logic [3:0] lowside_overcurrent_threshold,
	input wire logic [3:0] highside_ground_fault_threshold,
	input wire logic irq
);
	logic take, wr_cfg_d, wr_cfg_q, wr_ctl_d, wr_ctl_q, wr_msk_d, wr_msk_q;
	logic [31:0] wd_d, wd_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// remember which register the coming data phase writes, and its data
	always_comb begin
		take = hsel && hready && htrans[1];
		wr_cfg_d = take && hwrite && (haddr == 8'h00);
		wr_ctl_d = take && hwrite && (haddr == 8'h08);
		wr_msk_d = take && hwrite && (haddr == 8'h14);
		wd_d = (wr_cfg_q || wr_ctl_q || wr_msk_q) ? hwdata : wd_q;
	end
	always_ff @(posedge ref_clk) begin
		wr_cfg_q <= rst ? 1'b0 : wr_cfg_d;
		wr_ctl_q <= rst ? 1'b0 : wr_ctl_d;
		wr_msk_q <= rst ? 1'b0 : wr_msk_d;
		wd_q <= wd_d;
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_READY_OKAY: assert property (hreadyout == 1'b1 && hresp == 1'b0)
		else $error("slave stalled or answered an error");
	AST_RESET_OUTS: assert property (@(posedge ref_clk) disable iff (1'b0)
		rst |=> (bridge_enable == '0 && fault_n == 1'b1 && irq == 1'b0 && hrdata == 32'h0))
		else $error("outputs not at reset values");
	AST_RDATA_IDLE: assert property (!(take && !hwrite) |=> hrdata == 32'h0)
		else $error("read data outside a read data phase");
	AST_HS_THR_MIN: assert property (highside_ground_fault_threshold >= 4'h2)
		else $error("high-side threshold below its most sensitive step");
	AST_THR_WRITE: assert property (wr_cfg_q |-> ##[1:2] (lowside_overcurrent_threshold == wd_q[3:0]
		&& (wd_q[7:4] < 4'h2 || highside_ground_fault_threshold == wd_q[7:4])))
		else $error("threshold outputs do not follow the written field");
	AST_OT_OFF: assert property (temp_cmp[3] [*8] |=> bridge_enable == '0)
		else $error("bridges still on above the top shutdown level");
	AST_OT_HOLD: assert property (temp_cmp[3] [*8] ##1 temp_cmp[0] [*8] |-> bridge_enable == '0)
		else $error("bridges back on before cooling below prewarn");
	AST_DISABLE_OFF: assert property (wr_ctl_q && !hwdata[0] |-> ##[1:3] bridge_enable == '0)
		else $error("bridges on after driver disable");
	AST_MASK_OFF: assert property (wr_msk_q && hwdata[7:0] == 8'h00 |-> ##[1:3] !irq)
		else $error("interrupt high with every source masked");
endmodule
bind bridge_fault_protection bridge_prot_chk #(.phases(phases)) bridge_prot_chk_inst (.ref_clk(ref_clk), .rst(rst),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .temp_cmp(temp_cmp), .bridge_enable(bridge_enable),
	.lowside_overcurrent_threshold(lowside_overcurrent_threshold),
	.highside_ground_fault_threshold(highside_ground_fault_threshold), .fault_n(fault_n), .irq(irq));

// File: sim/bridge_stage_model.sv
// partner: three half bridges whose fet drop comparators trip on a commanded short
`timescale 1ns/1ps
module bridge_stage_model (
	input wire logic [2:0] gate_hs,
	input wire logic [2:0] gate_ls,
	input wire logic [2:0] bridge_enable,
	input wire logic [2:0] short_hs,
	input wire logic [2:0] short_ls,
	output logic [2:0] hs_drop_cmp,
	output logic [2:0] ls_drop_cmp
);
	// a fet shows drop only while it conducts into the short; a disabled phase conducts nothing
	assign hs_drop_cmp = gate_hs & bridge_enable & short_hs;
	assign ls_drop_cmp = gate_ls & bridge_enable & short_ls;
endmodule

// File: sim/tb_bridge_fault_protection.sv
// testbench: register-level tests of bridge fault protection
`timescale 1ns/1ps
module tb_bridge_fault_protection;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = bridge_prot_pkg::trans_idle;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0] temp_cmp = 4'h0;
	logic [2:0] gate_hs = 3'h0, gate_ls = 3'h0, short_hs = 3'h0, short_ls = 3'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, fault_n, irq;
	logic [2:0] hs_drop_cmp, ls_drop_cmp, bridge_enable;
	logic [3:0] lo_thr, hi_thr;
	int num_errors = 0, compares = 0, cyc = 0, n;
	// ----------------------------------------
	// clock, instances, timeout
	// ----------------------------------------
	always #5 ref_clk = ~ref_clk;
	bridge_fault_protection bridge_fault_protection_inst (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .otp_lowside_thr(4'h6), .otp_highside_thr(4'h1), .temp_cmp(temp_cmp),
		.gate_hs(gate_hs), .gate_ls(gate_ls), .hs_drop_cmp(hs_drop_cmp), .ls_drop_cmp(ls_drop_cmp),
		.bridge_enable(bridge_enable), .lowside_overcurrent_threshold(lo_thr),
		.highside_ground_fault_threshold(hi_thr), .fault_n(fault_n), .irq(irq));
	bridge_stage_model bridge_stage_model_inst (.gate_hs(gate_hs), .gate_ls(gate_ls), .bridge_enable(bridge_enable),
		.short_hs(short_hs), .short_ls(short_ls), .hs_drop_cmp(hs_drop_cmp), .ls_drop_cmp(ls_drop_cmp));
	// a hung wait would otherwise never end the run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	// one ahb-lite single transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= bridge_prot_pkg::trans_nonseq;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= bridge_prot_pkg::trans_idle;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	// cycles until the given phase is switched off
	task automatic fall(input int i);
		n = 0;
		while (bridge_enable[i] !== 1'b0) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	// driver off then on again, the only way out of a latched short shutdown
	task automatic restart(input logic [31:0] c);
		bus(1'b1, 8'h08, 32'h0);
		bus(1'b1, 8'h08, c);
		tick(8);
	endtask
	task automatic wrap_up();
		$display("counts: %0d mismatches in %0d compares", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		tick(6);
		rst <= 1'b0;
		tick(2);
		rchk(8'h00, 32'h8d26);
		chk({28'h0, lo_thr}, 32'h6);
		chk({28'h0, hi_thr}, 32'h2);
		rchk(8'h14, 32'h0);
		rchk(8'h40, 32'h0);
		$display("test reset done");
		bus(1'b1, 8'h00, 32'h80f3);
		rchk(8'h00, 32'h80f3);
		chk({24'h0, hi_thr, lo_thr}, 32'hf3);
		bus(1'b1, 8'h14, 32'h4);
		restart(32'h1);
		chk({29'h0, bridge_enable}, 32'h7);
		gate_hs <= 3'h1;
		short_hs <= 3'h1;
		fall(0);
		chk({31'h0, n inside {[85:95]}}, 32'h1);
		tick(3);
		chk({29'h0, bridge_enable}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		rchk(8'h0c, 32'h802);
		bus(1'b1, 8'h10, 32'h4);
		tick(3);
		chk({31'h0, irq}, 32'h0);
		gate_hs <= 3'h0;
		short_hs <= 3'h0;
		restart(32'h1);
		chk({29'h0, bridge_enable}, 32'h7);
		rchk(8'h0c, 32'h0);
		$display("test short done");
		bus(1'b1, 8'h00, 32'h15f3);
		gate_ls <= 3'h2;
		short_ls <= 3'h2;
		fall(1);
		chk({31'h0, n inside {[250:260]}}, 32'h1);
		chk({30'h0, bridge_enable[2], bridge_enable[0]}, 32'h3);
		rchk(8'h0c, 32'h0a0);
		n = 0;
		do begin
			bus(1'b0, 8'h0c, 32'h0);
			n++;
		end while (rd[11] !== 1'b1 && n < 300);
		chk(rd, 32'h8a0);
		chk({29'h0, bridge_enable}, 32'h5);
		gate_ls <= 3'h0;
		short_ls <= 3'h0;
		restart(32'h1);
		$display("test retry done");
		// each detector switched off in turn while its fet sees a short
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, 8'h00, (i == 0) ? 32'h20f3 : 32'h40f3);
			gate_hs <= 3'h4;
			gate_ls <= 3'h4;
			short_ls <= (i == 0) ? 3'h4 : 3'h0;
			short_hs <= (i == 0) ? 3'h0 : 3'h4;
			tick(300);
			chk({29'h0, bridge_enable}, 32'h7);
			rchk(8'h0c, 32'h0);
		end
		short_hs <= 3'h0;
		short_ls <= 3'h0;
		gate_ls <= 3'h0;
		$display("test detect off done");
		bus(1'b1, 8'h00, 32'h03f3);
		bus(1'b1, 8'h08, 32'h3);
		gate_hs <= 3'h1;
		tick(200);
		short_hs <= 3'h1;
		n = 0;
		while (fault_n !== 1'b0 && n < 10) begin
			tick(1);
			n++;
		end
		chk({31'h0, fault_n}, 32'h0);
		tick(20);
		short_hs <= 3'h0;
		gate_hs <= 3'h0;
		tick(8);
		chk({31'h0, fault_n}, 32'h1);
		rchk(8'h0c, 32'h0);
		$display("test direct done");
		bus(1'b1, 8'h10, 32'hf);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, 8'h04, 32'(i));
			temp_cmp <= 4'hf >> (2 - i);
			tick(12);
			chk({29'h0, bridge_enable}, 32'h0);
			rchk(8'h0c, 32'h600);
			temp_cmp <= 4'h1;
			tick(12);
			chk({29'h0, bridge_enable}, 32'h0);
			temp_cmp <= 4'h0;
			tick(12);
			chk({29'h0, bridge_enable}, 32'h7);
		end
		temp_cmp <= 4'h7;
		tick(12);
		chk({29'h0, bridge_enable}, 32'h7);
		temp_cmp <= 4'h0;
		bus(1'b1, 8'h14, 32'h3);
		tick(3);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 8'h14, 32'h0);
		tick(3);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h10, 32'h3);
		rchk(8'h10, 32'h0);
		$display("test temperature done");
		wrap_up();
	end
endmodule
